// file: tfa_pkg.sv
// Package for the transmit fault action block: fault indices, action codes, timing.
// Assumes one 50 MHz clock domain shared by all users.
package tfa_pkg;
  // Fault vector positions
  localparam int FLT_NO_CLK    = 0;
  localparam int FLT_SRC_READY = 1;
  localparam int FLT_SRC_VALID = 2;
  localparam int FLT_AIS_ALL   = 3;
  localparam int FLT_FRAME     = 4;
  localparam int FLT_DROP_AIS  = 5;
  localparam int FLT_CRC       = 6;
  localparam int FLT_BER       = 7;
  localparam int FLT_MF        = 8;
  localparam int FLT_PORTS     = 9;
  localparam int NUM_FLT       = 10;
  localparam int NUM_PORTS     = 4;

  // Frame alignment word error window for the BER check
  localparam int          BER_WINDOW_FAW = 1000;
  localparam int          BER_ERR_LIMIT  = 1;
  localparam logic [9:0]  BER_WIN_LAST   = 10'(BER_WINDOW_FAW - 1);
  localparam logic [9:0]  BER_ERR_MAX    = 10'(BER_ERR_LIMIT);

  // Clock loss watchdog: 1000 ns at 50 MHz, rounded down
  localparam int          CLK_PERIOD_NS  = 20;
  localparam int          CLK_LOSS_NS    = 1000;
  localparam logic [7:0]  CLK_LOSS_CYC   = 8'(CLK_LOSS_NS / CLK_PERIOD_NS);

  // Reset values
  localparam logic        FLAG_RST       = 1'b0;
  localparam logic [7:0]  CNT8_RST       = 8'h00;
  localparam logic [9:0]  CNT10_RST      = 10'h000;

  // Action bits per fault
  typedef struct packed {
    logic unit_relay;
    logic traffic_relay;
    logic deferred_relay;
    logic ter_ais;
    logic ter_frame_ba;
    logic ter_cas_ais;
    logic ter_cas_fixed;
    logic sat_mf_ba;
    logic sat_ais;
    logic sat_frame_ba;
    logic sat_cas_ais;
    logic carrier_mute;
    logic cts_off;
    logic rx_ready_off;
  } tfa_action_t;
endpackage : tfa_pkg

// file: tfa_fault_if.sv
// Interface carrying the fault vector and merged actions between the modules.
// Assumes all three modules share the same clock.
`timescale 1ns/100ps
`default_nettype none
interface tfa_fault_if;
  import tfa_pkg::*;
  logic [NUM_FLT-1:0] fault;
  tfa_action_t        action;
  modport detect (output fault);
  modport map    (input fault, output action);
  modport use_it (input fault, input action);
endinterface : tfa_fault_if
`default_nettype wire

// file: tfa_action_map.sv
// Maps each live fault onto its relay, terrestrial, satellite and line actions.
// Assumes faults are levels; actions are combinational and follow them.
`timescale 1ns/100ps
`default_nettype none
module tfa_action_map (
  tfa_fault_if.map    fi,
  // Options
  input  wire logic   mf_alarm_mode_in,
  input  wire logic   rts_carrier_ctl_in,
  input  wire logic   cas_fixed_sel_in
);
  import tfa_pkg::*;

  always_comb begin
    fi.action = '0;
    // Relays follow the fault directly, so release is automatic
    if (fi.fault[FLT_NO_CLK]) begin
      fi.action.traffic_relay = 1'b1;
      fi.action.ter_frame_ba  = 1'b1;
      fi.action.sat_ais       = 1'b1;
      fi.action.sat_cas_ais   = 1'b1;
    end
    if (fi.fault[FLT_SRC_READY]) begin
      fi.action.traffic_relay = 1'b1;
    end
    if (fi.fault[FLT_SRC_VALID]) begin
      fi.action.traffic_relay = 1'b1;
      fi.action.carrier_mute  = rts_carrier_ctl_in;
    end
    if (fi.fault[FLT_AIS_ALL] || fi.fault[FLT_FRAME]) begin
      fi.action.traffic_relay = 1'b1;
      fi.action.ter_frame_ba  = 1'b1;
      fi.action.sat_ais       = 1'b1;
      fi.action.sat_cas_ais   = 1'b1;
    end
    if (fi.fault[FLT_DROP_AIS] || fi.fault[FLT_BER]) begin
      fi.action.traffic_relay = 1'b1;
      fi.action.ter_frame_ba  = 1'b1;
      fi.action.sat_ais       = 1'b1;
    end
    if (fi.fault[FLT_CRC] || fi.fault[FLT_PORTS]) begin
      fi.action.traffic_relay = 1'b1;
    end
    if (fi.fault[FLT_MF]) begin
      fi.action.traffic_relay = 1'b1;
      fi.action.sat_cas_ais   = 1'b1;
      if (mf_alarm_mode_in) begin
        fi.action.sat_mf_ba = 1'b1;
      end else begin
        fi.action.ter_frame_ba = 1'b1;
      end
    end
    // Terrestrial AIS follows any fault that sends satellite AIS; CAS nibble forcing follows satellite CAS AIS
    fi.action.ter_ais = fi.action.sat_ais;
    if (fi.action.sat_cas_ais) begin
      fi.action.ter_cas_ais   = ~cas_fixed_sel_in;
      fi.action.ter_cas_fixed = cas_fixed_sel_in;
    end
    // Unit and deferred relays unused by these faults; flow control off for source faults
    fi.action.unit_relay     = 1'b0;
    fi.action.deferred_relay = 1'b0;
    fi.action.cts_off        = fi.fault[FLT_SRC_VALID];
    fi.action.rx_ready_off   = fi.fault[FLT_SRC_READY];
  end
endmodule : tfa_action_map
`default_nettype wire

// file: tfa_fault_top.sv
// Top of the transmit fault action block: detectors, action map, output stage.
// Assumes sync, CRC and AIS indications come from the framer in the mclk_in domain.
`timescale 1ns/100ps
`default_nettype none
module tfa_fault_top (
  // Clock and reset
  input  wire logic                          mclk_in,
  input  wire logic                          rstn_in,
  // Source handshake and clock
  input  wire logic                          source_ready_line_in,
  input  wire logic                          source_valid_line_in,
  input  wire logic                          ext_clk_sel_in,
  input  wire logic                          ext_clk_edge_in,
  // Framer indications
  input  wire logic                          all_ones_in,
  input  wire logic                          drop_all_ones_in,
  input  wire logic                          frame_sync_in,
  input  wire logic                          crc_sync_in,
  input  wire logic                          mf_sync_in,
  input  wire logic                          faw_strobe_in,
  input  wire logic                          faw_error_in,
  input  wire logic [tfa_pkg::NUM_PORTS-1:0] port_sync_in,
  // Configuration
  input  wire logic                          drop_mux_on_in,
  input  wire logic                          insert_mux_on_in,
  input  wire logic                          mode_2048k_in,
  input  wire logic                          zero_overhead_in,
  input  wire logic                          crc_enable_in,
  input  wire logic                          cas_enable_in,
  input  wire logic                          crc_reframe_in,
  input  wire logic                          ais_alarm_en_in,
  input  wire logic                          thin_route_in,
  input  wire logic                          rs_enable_in,
  input  wire logic                          mf_alarm_mode_in,
  input  wire logic                          rts_carrier_ctl_in,
  input  wire logic                          cas_fixed_sel_in,
  // Relays
  output logic                               unit_relay_out,
  output logic                               traffic_relay_out,
  output logic                               deferred_relay_out,
  // Terrestrial actions
  output logic                               ter_ais_slots_out,
  output logic                               ter_ais_all_out,
  output logic                               ter_frame_ba_out,
  output logic                               ter_cas_ais_out,
  output logic                               ter_cas_fixed_out,
  // Satellite actions
  output logic                               sat_ais_out,
  output logic                               sat_ais_rs_out,
  output logic                               sat_frame_ba_out,
  output logic                               sat_mf_ba_out,
  output logic                               sat_cas_ais_out,
  // Line actions and status
  output logic                               carrier_mute_out,
  output logic                               cts_out,
  output logic                               rx_ready_output_out,
  output logic                               use_int_clk_out,
  output logic                               reframe_out,
  output logic [tfa_pkg::NUM_PORTS-1:0]      port_fault_out,
  output logic [tfa_pkg::NUM_FLT-1:0]        fault_out
);
  import tfa_pkg::*;

  tfa_fault_if fi ();

  logic       clk_lost_reg;
  logic [9:0] faw_cnt_reg;
  logic [9:0] faw_err_reg;
  logic       ber_bad_reg;
  logic       frame_seek;
  logic       crc_seek;
  logic       mf_seek;

  // Search qualifiers: outside these modes a lost frame, CRC or multiframe sync is not a fault
  assign frame_seek = drop_mux_on_in | mode_2048k_in;
  assign crc_seek   = (drop_mux_on_in | (mode_2048k_in & zero_overhead_in)) & crc_enable_in;
  assign mf_seek    = (drop_mux_on_in | (mode_2048k_in & zero_overhead_in)) & cas_enable_in;

  // Clock loss watchdog; one edge pulse restarts it
  tfa_clk_watch u_clk_watch (
    .mclk_in        (mclk_in),
    .rstn_in        (rstn_in),
    .enable_in      (ext_clk_sel_in),
    .edge_in        (ext_clk_edge_in),
    .lost_out       (clk_lost_reg)
  );

  // Error rate over a fixed window of frame alignment words
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      faw_cnt_reg <= CNT10_RST;
      faw_err_reg <= CNT10_RST;
      ber_bad_reg <= FLAG_RST;
    end else if (!frame_seek) begin
      faw_cnt_reg <= CNT10_RST;
      faw_err_reg <= CNT10_RST;
      ber_bad_reg <= FLAG_RST;
    end else if (faw_strobe_in) begin
      if (faw_cnt_reg == BER_WIN_LAST) begin
        faw_cnt_reg <= CNT10_RST;
        faw_err_reg <= CNT10_RST;
        // More than one bad word in 1000 is worse than 1E-3
        ber_bad_reg <= (faw_err_reg + 10'(faw_error_in)) > BER_ERR_MAX;
      end else begin
        faw_cnt_reg <= faw_cnt_reg + 10'h001;
        if (faw_error_in && faw_err_reg != 10'h3ff) begin
          faw_err_reg <= faw_err_reg + 10'h001;
        end
      end
    end
  end

  // Fault vector: levels, so each clears with its cause
  always_comb begin
    fi.fault                = '0;
    fi.fault[FLT_NO_CLK]    = clk_lost_reg;
    fi.fault[FLT_SRC_READY] = ~source_ready_line_in;
    fi.fault[FLT_SRC_VALID] = ~source_valid_line_in;
    fi.fault[FLT_AIS_ALL]   = all_ones_in & ais_alarm_en_in;
    fi.fault[FLT_FRAME]     = frame_seek & (~frame_sync_in | (crc_reframe_in & crc_seek & ~crc_sync_in));
    fi.fault[FLT_DROP_AIS]  = drop_mux_on_in & drop_all_ones_in & ~all_ones_in;
    fi.fault[FLT_CRC]       = crc_seek & ~crc_sync_in;
    fi.fault[FLT_BER]       = ber_bad_reg;
    fi.fault[FLT_MF]        = mf_seek & frame_sync_in & ~mf_sync_in;
    fi.fault[FLT_PORTS]     = ~&port_sync_in;
  end

  tfa_action_map u_map (
    .fi                 (fi),
    .mf_alarm_mode_in   (mf_alarm_mode_in),
    .rts_carrier_ctl_in (rts_carrier_ctl_in),
    .cas_fixed_sel_in   (cas_fixed_sel_in)
  );

  // Relays and line actions, registered so outputs come from flops
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      unit_relay_out      <= FLAG_RST;
      traffic_relay_out   <= FLAG_RST;
      deferred_relay_out  <= FLAG_RST;
      carrier_mute_out    <= FLAG_RST;
      cts_out             <= FLAG_RST;
      rx_ready_output_out <= FLAG_RST;
      use_int_clk_out     <= FLAG_RST;
      reframe_out         <= FLAG_RST;
    end else begin
      unit_relay_out      <= fi.action.unit_relay;
      traffic_relay_out   <= fi.action.traffic_relay;
      deferred_relay_out  <= fi.action.deferred_relay;
      carrier_mute_out    <= fi.action.carrier_mute;
      cts_out             <= ~fi.action.cts_off;
      rx_ready_output_out <= ~fi.action.rx_ready_off;
      use_int_clk_out     <= ~ext_clk_sel_in | clk_lost_reg;
      reframe_out         <= crc_reframe_in & crc_seek & ~crc_sync_in;
    end
  end

  // Terrestrial and satellite insertion actions
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      ter_ais_slots_out <= FLAG_RST;
      ter_ais_all_out   <= FLAG_RST;
      ter_frame_ba_out  <= FLAG_RST;
      ter_cas_ais_out   <= FLAG_RST;
      ter_cas_fixed_out <= FLAG_RST;
      sat_ais_out       <= FLAG_RST;
      sat_ais_rs_out    <= FLAG_RST;
      sat_frame_ba_out  <= FLAG_RST;
      sat_mf_ba_out     <= FLAG_RST;
      sat_cas_ais_out   <= FLAG_RST;
    end else begin
      // Insert mode limits AIS to its slots unless thin route spoofing wants the whole bearer
      ter_ais_slots_out <= fi.action.ter_ais & insert_mux_on_in & ~thin_route_in;
      ter_ais_all_out   <= fi.action.ter_ais & (~insert_mux_on_in | thin_route_in);
      ter_frame_ba_out  <= fi.action.ter_frame_ba;
      ter_cas_ais_out   <= fi.action.ter_cas_ais;
      ter_cas_fixed_out <= fi.action.ter_cas_fixed;
      sat_ais_out       <= fi.action.sat_ais;
      sat_ais_rs_out    <= fi.action.sat_ais & rs_enable_in;
      sat_frame_ba_out  <= fi.action.sat_frame_ba;
      sat_mf_ba_out     <= fi.action.sat_mf_ba;
      sat_cas_ais_out   <= fi.action.sat_cas_ais;
    end
  end

  // Status reporting
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      port_fault_out <= '0;
      fault_out      <= '0;
    end else begin
      port_fault_out <= ~port_sync_in;
      fault_out      <= fi.fault;
    end
  end
endmodule : tfa_fault_top
`default_nettype wire

// file: clk_watch.sv
// Watchdog that flags a missing external transmit clock.
// Assumes edge_in is a one-cycle pulse per external clock edge, synchronous to mclk_in.
`timescale 1ns/100ps
`default_nettype none
module tfa_clk_watch (
  input  wire logic mclk_in,
  input  wire logic rstn_in,
  input  wire logic enable_in,
  input  wire logic edge_in,
  output logic      lost_out
);
  import tfa_pkg::*;

  logic [7:0] cnt_reg;

  always_ff @(posedge mclk_in) begin
    if (!rstn_in || !enable_in || edge_in) begin
      cnt_reg  <= CNT8_RST;
      lost_out <= FLAG_RST;
    end else if (cnt_reg == CLK_LOSS_CYC) begin
      lost_out <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 8'h01;
    end
  end
endmodule : tfa_clk_watch
`default_nettype wire

// file: tfa_fault_props.sv
// Checker on the transmit fault action top ports.
// Assumes it is bound to tfa_fault_top; one mclk_in domain.
`timescale 1ns/100ps
`default_nettype none
module tfa_fault_props (
  // Clock, reset and causes
  input wire logic       mclk_in,
  input wire logic       rstn_in,
  input wire logic       source_ready_line_in,
  input wire logic       source_valid_line_in,
  input wire logic       ext_clk_sel_in,
  input wire logic       ext_clk_edge_in,
  input wire logic       all_ones_in,
  input wire logic       ais_alarm_en_in,
  input wire logic       drop_mux_on_in,
  input wire logic       mode_2048k_in,
  input wire logic       crc_enable_in,
  input wire logic       rts_carrier_ctl_in,
  input wire logic [3:0] port_sync_in,
  // Actions
  input wire logic       traffic_relay_out,
  input wire logic       rx_ready_output_out,
  input wire logic       carrier_mute_out,
  input wire logic       cts_out,
  input wire logic       ter_frame_ba_out,
  input wire logic       sat_ais_out,
  input wire logic       sat_cas_ais_out,
  input wire logic       use_int_clk_out,
  input wire logic [3:0] port_fault_out,
  input wire logic [9:0] fault_out
);
  logic [7:0] quiet_cnt_reg;
  // Saturates so a long outage never wraps under the limit
  always_ff @(posedge mclk_in) begin
    if (!rstn_in || ext_clk_edge_in || !ext_clk_sel_in)
      quiet_cnt_reg <= 8'h00;
    else if (quiet_cnt_reg != 8'hff)
      quiet_cnt_reg <= quiet_cnt_reg + 8'h01;
  end
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rstn_in);
  sequence stop_req_s; !source_valid_line_in && rts_carrier_ctl_in; endsequence
  sequence muted_s; carrier_mute_out && !cts_out && traffic_relay_out; endsequence
  sequence ais_acts_s; traffic_relay_out && ter_frame_ba_out && sat_ais_out && sat_cas_ais_out; endsequence
  ready_relay_a: assert property (!source_ready_line_in |=> traffic_relay_out && !rx_ready_output_out)
    else $error("no traffic relay after source ready drop");
  stop_mute_a: assert property (stop_req_s |=> muted_s)
    else $error("carrier not muted on stop request");
  ais_alarm_a: assert property (all_ones_in && ais_alarm_en_in |=> ais_acts_s)
    else $error("all ones input actions missing");
  frame_mask_a: assert property (!drop_mux_on_in && !mode_2048k_in |=> !fault_out[4])
    else $error("frame fault while not seeking");
  crc_mask_a: assert property (!crc_enable_in |=> !fault_out[6])
    else $error("crc fault while processing off");
  port_fault_a: assert property (port_sync_in != 4'hf |=>
    traffic_relay_out && port_fault_out == ~$past(port_sync_in)) else $error("port fault report wrong");
  relay_sum_a: assert property (traffic_relay_out == (|fault_out))
    else $error("traffic relay does not follow faults");
  clk_lost_a: assert property (quiet_cnt_reg >= 8'h37 |-> fault_out[0] && use_int_clk_out)
    else $error("clock loss not flagged");
  clk_early_a: assert property ($rose(fault_out[0]) |-> quiet_cnt_reg >= 8'h2d)
    else $error("clock loss flagged too early");
endmodule : tfa_fault_props
`default_nettype wire

// file: tfa_src_model.sv
// Behavioural terrestrial data source: handshake lines, clock edges, FAW strobes.
// Assumes the bench steers it through plain control levels.
`timescale 1ns/100ps
`default_nettype none
module tfa_src_model (
  // Control from the bench
  input  wire logic mclk_in,
  input  wire logic clk_run_in,
  input  wire logic ready_ok_in,
  input  wire logic valid_ok_in,
  // Lines toward the modem
  output logic      source_ready_line_out,
  output logic      source_valid_line_out,
  output logic      clk_edge_out,
  output logic      faw_strobe_out
);
  logic [1:0] phase_reg = 2'h0;
  assign source_ready_line_out = ready_ok_in;
  assign source_valid_line_out = valid_ok_in;
  assign faw_strobe_out = 1'b1;
  initial clk_edge_out = 1'b0;
  // Stopped clock stands still; running clock edges every fourth cycle
  always @(negedge mclk_in) begin
    phase_reg <= phase_reg + 2'h1;
    clk_edge_out <= clk_run_in && (phase_reg == 2'h0);
  end
endmodule : tfa_src_model
`default_nettype wire

// file: tfa_fault_top_tb.sv
// Self-checking bench for the transmit fault action block.
// Assumes the package, interface and design modules are compiled first.
`timescale 1ns/100ps
`default_nettype none
module tfa_fault_top_tb;
  logic        mclk, rstn, clk_run, rdy_ok, vld_ok, faw_err, rdy_l, vld_l, edge_l, strobe_l, refr, intclk;
  logic [12:0] cfg;
  logic [5:0]  fr;
  logic [3:0]  psync, pflt;
  logic [15:0] act;
  logic [9:0]  flt;
  logic [31:0] exp_q[$];
  int          err_count, comparisons, n, i;
  bit   [31:0] r;
  tfa_src_model i_src (.mclk_in(mclk), .clk_run_in(clk_run), .ready_ok_in(rdy_ok), .valid_ok_in(vld_ok),
    .source_ready_line_out(rdy_l), .source_valid_line_out(vld_l), .clk_edge_out(edge_l), .faw_strobe_out(strobe_l));
  tfa_fault_top i_dut (.mclk_in(mclk), .rstn_in(rstn), .source_ready_line_in(rdy_l), .source_valid_line_in(vld_l),
    .ext_clk_sel_in(fr[5]), .ext_clk_edge_in(edge_l), .all_ones_in(fr[0]), .drop_all_ones_in(fr[1]),
    .frame_sync_in(fr[2]), .crc_sync_in(fr[3]), .mf_sync_in(fr[4]), .faw_strobe_in(strobe_l),
    .faw_error_in(faw_err), .port_sync_in(psync), .drop_mux_on_in(cfg[0]), .insert_mux_on_in(cfg[1]),
    .mode_2048k_in(cfg[2]), .zero_overhead_in(cfg[3]), .crc_enable_in(cfg[4]), .cas_enable_in(cfg[5]),
    .crc_reframe_in(cfg[6]), .ais_alarm_en_in(cfg[7]), .thin_route_in(cfg[8]), .rs_enable_in(cfg[9]),
    .mf_alarm_mode_in(cfg[10]), .rts_carrier_ctl_in(cfg[11]), .cas_fixed_sel_in(cfg[12]),
    .unit_relay_out(act[15]), .traffic_relay_out(act[14]), .deferred_relay_out(act[13]),
    .ter_ais_slots_out(act[12]), .ter_ais_all_out(act[11]), .ter_frame_ba_out(act[10]),
    .ter_cas_ais_out(act[9]), .ter_cas_fixed_out(act[8]), .sat_ais_out(act[7]), .sat_ais_rs_out(act[6]),
    .sat_frame_ba_out(act[5]), .sat_mf_ba_out(act[4]), .sat_cas_ais_out(act[3]), .carrier_mute_out(act[2]),
    .cts_out(act[1]), .rx_ready_output_out(act[0]), .use_int_clk_out(intclk), .reframe_out(refr),
    .port_fault_out(pflt), .fault_out(flt));
  always #10 mclk = ~mclk;
  // Expected outputs from the current inputs, clock running and no FAW errors
  function automatic logic [31:0] model();
    logic [9:0] f;
    logic       seek, sa, sc;
    seek = cfg[0] | (cfg[2] & cfg[3]);
    f = 10'h000;
    f[1] = !rdy_ok;
    f[2] = !vld_ok;
    f[3] = fr[0] & cfg[7];
    f[6] = !fr[3] & seek & cfg[4];
    // Reframe option turns a lost CRC sync into a frame fault too
    f[4] = (!fr[2] | (cfg[6] & f[6])) & (cfg[0] | cfg[2]);
    f[5] = fr[1] & !fr[0] & cfg[0];
    f[8] = !fr[4] & seek & cfg[5] & fr[2];
    f[9] = psync != 4'hf;
    sa = f[3] | f[4] | f[5];
    sc = f[3] | f[4] | f[8];
    return {1'b0, |f, 1'b0, sa & cfg[1] & !cfg[8], sa & (!cfg[1] | cfg[8]), sa | (f[8] & !cfg[10]),
            sc & !cfg[12], sc & cfg[12], sa, sa & cfg[9], 1'b0, f[8] & cfg[10], sc, f[2] & cfg[11],
            !f[2], !f[1], f, ~psync, !fr[5], cfg[6] & f[6]};
  endfunction : model
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  task automatic wait_flt(input int idx, input logic val, input int bound);
    n = 0;
    while (flt[idx] !== val) begin
      @(negedge mclk);
      n++;
      if (n > bound) begin
        err_count++;
        $display("CHECK FAILED fault bit %0d expected %b seen %b", idx, val, flt[idx]);
        final_report();
      end
    end
  endtask : wait_flt
  initial begin
    mclk = 1'b0; rstn = 1'b0; clk_run = 1'b1; rdy_ok = 1'b1; vld_ok = 1'b1; faw_err = 1'b0;
    cfg = 13'h0000; fr = 6'h1c; psync = 4'hf; err_count = 0; comparisons = 0;
    void'($urandom(32'hb8dff9d9));
    repeat (4) @(negedge mclk);
    chk("reset outputs", 32'h0, {act, flt, pflt, intclk, refr});
    rstn = 1'b1;
    $display("test reset done");
    for (i = 0; i < 500; i++) begin
      r = $urandom;
      cfg = r[31:19];
      fr = {r[10], |r[9:8], |r[7:6], |r[5:4], &r[3:2], &r[1:0]};
      {rdy_ok, vld_ok} = {|r[12:11], |r[14:13]};
      psync = r[18:15] | {r[17:15], r[18]};
      exp_q.push_back(model());
      @(negedge mclk);
      chk("outputs", exp_q.pop_front(), {act, flt, pflt, intclk, refr});
    end
    $display("test random faults done");
    rdy_ok = 1'b1; vld_ok = 1'b1; cfg = 13'h0000; fr = 6'h3c; psync = 4'hf;
    repeat (8) @(negedge mclk);
    clk_run = 1'b0;
    wait_flt(0, 1'b1, 80);
    chk("loss delay", 32'h1, 32'(n >= 45 && n <= 58));
    chk("loss actions", 32'h1f, 32'({act[14], act[10], act[7], act[3], intclk}));
    clk_run = 1'b1;
    wait_flt(0, 1'b0, 12);
    $display("test clock loss done");
    // Error rate is only measured while frame sync is sought
    fr = 6'h1c; cfg = 13'h0004;
    faw_err = 1'b1;
    wait_flt(7, 1'b1, 2100);
    chk("error rate actions", 32'h7, 32'({act[14], act[10], act[7]}));
    faw_err = 1'b0;
    wait_flt(7, 1'b0, 2100);
    faw_err = 1'b1;
    @(negedge mclk);
    faw_err = 1'b0;
    n = 0;
    repeat (2100) begin
      @(negedge mclk);
      if (flt[7] !== 1'b0) n++;
    end
    chk("single error window", 32'h0, 32'(n));
    $display("test error rate done");
    final_report();
  end
endmodule : tfa_fault_top_tb
bind tfa_fault_top tfa_fault_props i_props (.*);
`default_nettype wire
